// ==== rtl/dms_pkg.sv ====
// Shared constants and types of the DIO motion event synchroniser
package dms_pkg;

    // ***********************************************************
    // Geometry
    // ***********************************************************
    localparam int DIO_W = 16;        // Total digital I/O lines
    localparam int PORT_W = 8;        // Lines per port
    localparam int PORT_N = 2;        // Number of ports

    // ***********************************************************
    // Register byte offsets
    // ***********************************************************
    localparam logic [7:0] OFS_DIR = 8'h00;   // Port direction setting
    localparam logic [7:0] OFS_OUT = 8'h04;   // Output value, read/write
    localparam logic [7:0] OFS_SET = 8'h08;   // Write one to set bits
    localparam logic [7:0] OFS_CLR = 8'h0C;   // Write one to clear bits
    localparam logic [7:0] OFS_IN = 8'h10;    // Line levels, read only
    localparam logic [7:0] OFS_TRIG = 8'h14;  // Program trigger bits
    localparam logic [7:0] OFS_ESTOP = 8'h18; // Emergency stop config
    localparam logic [7:0] OFS_STAT = 8'h1C;  // Event status, read clears
    localparam logic [7:0] OFS_MASK = 8'h20;  // Event mask
    localparam logic [2:0] OFS_INH_BLK = 3'h2; // 0x40: inhibit per axis
    localparam logic [2:0] OFS_NTF_BLK = 3'h3; // 0x60: notify per axis

    // ***********************************************************
    // Field positions and reset values
    // ***********************************************************
    localparam int STAT_FALL_LSB = 0;   // Falling edge events 15:0
    localparam int STAT_LOCK_LSB = 16;  // Interlock events per axis
    localparam logic [1:0] DIR_RST = 2'h0;      // Both ports input
    localparam logic [15:0] OUT_RST = 16'h0000; // Output value
    localparam logic [15:0] TRIG_RST = 16'h0000; // No trigger bits
    localparam logic [1:0] ESTOP_RST = 2'h0;    // Stop behaviour code
    localparam logic [1:0] RESP_OKAY = 2'h0;    // AXI OKAY
    localparam logic [1:0] RESP_SLVERR = 2'h2;  // AXI SLVERR

    // Per axis bit assignment: [5] enable, [4] level, [3:0] bit
    typedef struct packed {
        logic enable;
        logic level;
        logic [3:0] bit_sel;
    } dms_axis_cfg_type;
    localparam dms_axis_cfg_type AXIS_CFG_RST = 6'h00;

endpackage

// ==== rtl/dms_dio_motion_event_sync.sv ====
// DIO block tying external events to motion, with AXI4-Lite registers

// Function
// - Sixteen lines in two eight-bit ports
// - Input port bits sample only, never drive
// - Output port bits drive, individually set/clear
// - Reset makes both ports input
// - Unconnected input line reads high
// - Direction value 02H: A input, B output
// - Falling edge on input-port trigger bit starts program
// - Inhibit needs bit, level, enable, input port
// - Asserted inhibit while moving causes emergency stop
// - Asserted inhibit while stationary rejects move commands
// - Both inhibit cases raise per-axis interlock error
// - Inhibit level one means high inhibits
// - Inhibit enable one switches inhibition on
// - Notify needs bit, level, enable, output port
// - Stationary axis drives bit to standstill level
// - Notify level one means high at standstill
// - Notify enable one switches notification on
module dms_dio_motion_event_sync #(
    parameter int N_AXES = 4,
    parameter int ADDR_W = 8
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // AXI4-Lite write channels
    input wire logic s_axi_awvalid_i,
    input wire logic [ADDR_W-1:0] s_axi_awaddr_i,
    output logic s_axi_awready_o,
    input wire logic s_axi_wvalid_i,
    input wire logic [31:0] s_axi_wdata_i,
    input wire logic [3:0] s_axi_wstrb_i,
    output logic s_axi_wready_o,
    output logic s_axi_bvalid_o,
    output logic [1:0] s_axi_bresp_o,
    input wire logic s_axi_bready_i,
    // AXI4-Lite read channels
    input wire logic s_axi_arvalid_i,
    input wire logic [ADDR_W-1:0] s_axi_araddr_i,
    output logic s_axi_arready_o,
    output logic s_axi_rvalid_o,
    output logic [31:0] s_axi_rdata_o,
    output logic [1:0] s_axi_rresp_o,
    input wire logic s_axi_rready_i,
    // Digital I/O lines (pulled up outside)
    input wire logic [15:0] digital_io_line_i,
    output logic [15:0] digital_io_line_o,
    output logic [15:0] digital_io_line_oe_o,
    // Motion core side
    input wire logic [N_AXES-1:0] axis_moving_i,
    input wire logic [N_AXES-1:0] move_cmd_i,
    output logic [15:0] program_start_o,
    output logic [N_AXES-1:0] estop_o,
    output logic [1:0] emergency_stop_config_o,
    output logic [N_AXES-1:0] move_reject_o,
    output logic [N_AXES-1:0] interlock_err_o,
    // Interrupt
    output logic irq_o
);

    // ***********************************************************
    // State
    // ***********************************************************
    localparam int STAT_W = dms_pkg::STAT_LOCK_LSB + N_AXES;

    typedef struct packed {
        logic [15:0] meta;      // First sync stage, read only by sync
        logic [15:0] sync;      // Second sync stage
        logic [15:0] prev;      // Last synchronised level, for edges
        logic [1:0] dir;        // One bit per port, 1 = output
        logic [15:0] out_val;   // Software output value
        logic [15:0] trig_en;   // Bits assigned to a stored program
        logic [1:0] estop_cfg;  // Stop behaviour passed to motion core
        dms_pkg::dms_axis_cfg_type [N_AXES-1:0] inh; // Inhibit config
        dms_pkg::dms_axis_cfg_type [N_AXES-1:0] ntf; // Notify config
        logic [STAT_W-1:0] stat; // Sticky events
        logic [STAT_W-1:0] mask; // Event mask
        logic [N_AXES-1:0] lock_prev; // Stop condition last cycle
        logic [15:0] dio_out;   // Driven line values
        logic [15:0] dio_oe;    // Line drive enables
        logic [15:0] prog_start; // Start pulses
        logic [N_AXES-1:0] estop;  // Stop request levels
        logic [N_AXES-1:0] reject; // Command refusal pulses
        logic [N_AXES-1:0] lock_err; // Interlock error pulses
        logic irq;              // Interrupt level
        logic wready;           // Shared awready/wready
        logic bvalid;           // Write response valid
        logic [1:0] bresp;      // Write response code
        logic arready;          // Read address ready
        logic rvalid;           // Read data valid
        logic [31:0] rdata;     // Read data
        logic [1:0] rresp;      // Read response code
    } dms_state_type;

    dms_state_type s;       // Registered state
    dms_state_type next_s;  // Next state

    // ***********************************************************
    // Helper nets
    // ***********************************************************
    logic [15:0] port_out;       // Per line: its port is output
    logic wr_fire;               // Write address and data taken
    logic rd_fire;               // Read address taken
    logic [31:0] wmask;          // Byte strobes widened to bits
    logic [7:0] waddr;           // Write byte offset
    logic [7:0] raddr;           // Read byte offset
    logic [N_AXES-1:0] inh_act;  // Inhibit asserted per axis
    logic [15:0] fall;           // Qualified falling edges

    // Port direction widened to lines
    assign port_out = {{dms_pkg::PORT_W{s.dir[1]}},
                       {dms_pkg::PORT_W{s.dir[0]}}};
    assign wr_fire = s.wready & s_axi_awvalid_i & s_axi_wvalid_i;
    assign rd_fire = s.arready & s_axi_arvalid_i;
    assign waddr = 8'(s_axi_awaddr_i);
    assign raddr = 8'(s_axi_araddr_i);
    assign wmask = {{8{s_axi_wstrb_i[3]}}, {8{s_axi_wstrb_i[2]}},
                    {8{s_axi_wstrb_i[1]}}, {8{s_axi_wstrb_i[0]}}};

    // Falling edge on an input-port trigger bit, after sync
    assign fall = s.prev & ~s.sync & ~port_out & s.trig_en;

    // ***********************************************************
    // Per-axis inhibit detection
    // ***********************************************************
    for (genvar a = 0; a < N_AXES; a++) begin : g_axis
        // Selected line matches level, enabled, port input
        // Level 1 inhibits on high, 0 on low
        // Enable 1 switches the feature on
        assign inh_act[a] = s.inh[a].enable
            & ~port_out[s.inh[a].bit_sel]
            & (s.sync[s.inh[a].bit_sel] == s.inh[a].level);
    end

    // ***********************************************************
    // Next state
    // ***********************************************************
    // Single combinational process; everything is registered below
    always_comb begin
        logic [15:0] drv;
        logic [N_AXES-1:0] lock_cond;
        logic [N_AXES-1:0] err_now;
        logic [STAT_W-1:0] stat_base;
        logic [2:0] widx;
        logic [2:0] ridx;
        drv = s.out_val;
        lock_cond = inh_act & axis_moving_i;
        err_now = '0;
        stat_base = s.stat;
        widx = waddr[4:2];
        ridx = raddr[4:2];
        next_s = s;

        // Two-stage line synchroniser, then edge history
        next_s.meta = digital_io_line_i;
        next_s.sync = s.meta;
        next_s.prev = s.sync;

        // Write channel: ready only once both halves are offered
        next_s.wready = s_axi_awvalid_i & s_axi_wvalid_i
            & ~s.wready & ~s.bvalid;
        if (s.bvalid & s_axi_bready_i) begin
            next_s.bvalid = 1'b0;
        end
        if (wr_fire) begin
            next_s.bvalid = 1'b1;
            next_s.bresp = dms_pkg::RESP_OKAY;
            if (waddr[7:5] == dms_pkg::OFS_INH_BLK) begin
                // Axis beyond the parameter count is unmapped
                if (32'(widx) < N_AXES && s_axi_wstrb_i[0]) begin
                    next_s.inh[widx] = s_axi_wdata_i[5:0];
                end else if (32'(widx) >= N_AXES) begin
                    next_s.bresp = dms_pkg::RESP_SLVERR;
                end
            end else if (waddr[7:5] == dms_pkg::OFS_NTF_BLK) begin
                if (32'(widx) < N_AXES && s_axi_wstrb_i[0]) begin
                    next_s.ntf[widx] = s_axi_wdata_i[5:0];
                end else if (32'(widx) >= N_AXES) begin
                    next_s.bresp = dms_pkg::RESP_SLVERR;
                end
            end else begin
                case (waddr)
                    dms_pkg::OFS_DIR: begin
                        // 02H gives port A input, port B output
                        if (s_axi_wstrb_i[0]) begin
                            next_s.dir = s_axi_wdata_i[1:0];
                        end
                    end
                    dms_pkg::OFS_OUT: begin
                        // Byte-lane merge of the output value
                        next_s.out_val = (s.out_val & ~wmask[15:0])
                            | (s_axi_wdata_i[15:0] & wmask[15:0]);
                    end
                    dms_pkg::OFS_SET: begin
                        // Individual set without read-modify-write
                        next_s.out_val = s.out_val
                            | (s_axi_wdata_i[15:0] & wmask[15:0]);
                    end
                    dms_pkg::OFS_CLR: begin
                        // Individual clear
                        next_s.out_val = s.out_val
                            & ~(s_axi_wdata_i[15:0] & wmask[15:0]);
                    end
                    dms_pkg::OFS_TRIG: begin
                        next_s.trig_en = (s.trig_en & ~wmask[15:0])
                            | (s_axi_wdata_i[15:0] & wmask[15:0]);
                    end
                    dms_pkg::OFS_ESTOP: begin
                        if (s_axi_wstrb_i[0]) begin
                            next_s.estop_cfg = s_axi_wdata_i[1:0];
                        end
                    end
                    dms_pkg::OFS_MASK: begin
                        next_s.mask = (s.mask & ~wmask[STAT_W-1:0])
                            | (s_axi_wdata_i[STAT_W-1:0]
                               & wmask[STAT_W-1:0]);
                    end
                    // Read-only registers accept and ignore writes
                    dms_pkg::OFS_IN, dms_pkg::OFS_STAT: begin
                    end
                    default: begin
                        next_s.bresp = dms_pkg::RESP_SLVERR;
                    end
                endcase
            end
        end

        // Read channel: one outstanding read, answer next cycle
        next_s.arready = s_axi_arvalid_i & ~s.arready & ~s.rvalid;
        if (s.rvalid & s_axi_rready_i) begin
            next_s.rvalid = 1'b0;
        end
        if (rd_fire) begin
            next_s.rvalid = 1'b1;
            next_s.rresp = dms_pkg::RESP_OKAY;
            next_s.rdata = 32'h0000_0000;
            if (raddr[7:5] == dms_pkg::OFS_INH_BLK) begin
                if (32'(ridx) < N_AXES) begin
                    next_s.rdata = 32'(s.inh[ridx]);
                end else begin
                    next_s.rresp = dms_pkg::RESP_SLVERR;
                end
            end else if (raddr[7:5] == dms_pkg::OFS_NTF_BLK) begin
                if (32'(ridx) < N_AXES) begin
                    next_s.rdata = 32'(s.ntf[ridx]);
                end else begin
                    next_s.rresp = dms_pkg::RESP_SLVERR;
                end
            end else begin
                case (raddr)
                    dms_pkg::OFS_DIR: next_s.rdata = 32'(s.dir);
                    dms_pkg::OFS_OUT: next_s.rdata = 32'(s.out_val);
                    dms_pkg::OFS_SET: next_s.rdata = 32'h0000_0000;
                    dms_pkg::OFS_CLR: next_s.rdata = 32'h0000_0000;
                    dms_pkg::OFS_IN: begin
                        // Input bits show the line; open line is high
                        // through the pull-up
                        next_s.rdata = 32'((s.sync & ~port_out)
                            | (s.dio_out & port_out));
                    end
                    dms_pkg::OFS_TRIG: next_s.rdata = 32'(s.trig_en);
                    dms_pkg::OFS_ESTOP: next_s.rdata = 32'(s.estop_cfg);
                    dms_pkg::OFS_STAT: begin
                        // Reading clears the sticky events
                        next_s.rdata = 32'(s.stat);
                        stat_base = '0;
                    end
                    dms_pkg::OFS_MASK: next_s.rdata = 32'(s.mask);
                    default: next_s.rresp = dms_pkg::RESP_SLVERR;
                endcase
            end
        end

        // Program start pulses, one per qualified edge
        next_s.prog_start = fall;

        // Stop request while moving and inhibited
        next_s.estop = lock_cond;
        // Refuse move commands while stationary and inhibited
        next_s.reject = inh_act & ~axis_moving_i & move_cmd_i;
        // Error on stop onset or on each refusal
        next_s.lock_prev = lock_cond;
        err_now = (lock_cond & ~s.lock_prev) | next_s.reject;
        next_s.lock_err = err_now;

        // New events win over a read clear in the same cycle
        next_s.stat = stat_base
            | {err_now, fall};
        next_s.irq = |(next_s.stat & next_s.mask);

        // Motion status notification overrides the software value
        for (int a = 0; a < N_AXES; a++) begin
            // Enabled and port output only
            if (s.ntf[a].enable & port_out[s.ntf[a].bit_sel]) begin
                if (axis_moving_i[a]) begin
                    // Opposite level while moving
                    drv[s.ntf[a].bit_sel] = ~s.ntf[a].level;
                end else begin
                    // Standstill level, 1 = high
                    drv[s.ntf[a].bit_sel] = s.ntf[a].level;
                end
            end
        end
        next_s.dio_out = drv;
        // Drive only lines of output ports
        next_s.dio_oe = port_out;
    end

    // ***********************************************************
    // State register
    // ***********************************************************
    // Asynchronous reset loads constants only
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            s <= '0;
            s.meta <= 16'hFFFF;
            s.sync <= 16'hFFFF;
            s.prev <= 16'hFFFF;
            s.dir <= dms_pkg::DIR_RST;   // Both ports input
            s.out_val <= dms_pkg::OUT_RST;
            s.trig_en <= dms_pkg::TRIG_RST;
            s.estop_cfg <= dms_pkg::ESTOP_RST;
            s.inh <= {N_AXES{dms_pkg::AXIS_CFG_RST}};
            s.ntf <= {N_AXES{dms_pkg::AXIS_CFG_RST}};
        end else begin
            s <= next_s;
        end
    end

    // ***********************************************************
    // Outputs, all straight from the state register
    // ***********************************************************
    assign s_axi_awready_o = s.wready;
    assign s_axi_wready_o = s.wready;
    assign s_axi_bvalid_o = s.bvalid;
    assign s_axi_bresp_o = s.bresp;
    assign s_axi_arready_o = s.arready;
    assign s_axi_rvalid_o = s.rvalid;
    assign s_axi_rdata_o = s.rdata;
    assign s_axi_rresp_o = s.rresp;
    assign digital_io_line_o = s.dio_out;
    assign digital_io_line_oe_o = s.dio_oe;
    assign program_start_o = s.prog_start;
    assign estop_o = s.estop;
    assign emergency_stop_config_o = s.estop_cfg;
    assign move_reject_o = s.reject;
    assign interlock_err_o = s.lock_err;
    assign irq_o = s.irq;

    // ***********************************************************
    // Assertions and covers (axis 1 and line 0 as samples)
    // ***********************************************************
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    property p_in_no_drive;
        ##1 digital_io_line_oe_o[7:0] == {8{$past(s.dir[0])}};
    endproperty
    a_in_no_drive: assert property (p_in_no_drive)
        else $error("Port A drive enable does not follow direction");

    property p_dir_02;
        (wr_fire && waddr == dms_pkg::OFS_DIR && s_axi_wstrb_i[0]
         && s_axi_wdata_i[1:0] == 2'h2)
        |=> ##1 digital_io_line_oe_o == 16'hFF00;
    endproperty
    a_dir_02: assert property (p_dir_02)
        else $error("Direction 02H did not give A in, B out");

    property p_start;
        (s.prev[0] && !s.sync[0] && s.trig_en[0] && !s.dir[0])
        |=> program_start_o[0];
    endproperty
    a_start: assert property (p_start)
        else $error("Falling edge did not start program");

    property p_one_start;
        program_start_o[0] |=> !program_start_o[0];
    endproperty
    a_one_start: assert property (p_one_start)
        else $error("Start pulse longer than one cycle");

    property p_estop;
        (inh_act[1] && axis_moving_i[1]) |=> estop_o[1];
    endproperty
    a_estop: assert property (p_estop)
        else $error("Inhibit while moving gave no stop");

    property p_reject;
        (inh_act[1] && !axis_moving_i[1] && move_cmd_i[1])
        |=> move_reject_o[1] && interlock_err_o[1];
    endproperty
    a_reject: assert property (p_reject)
        else $error("Inhibited move command not refused");

    property p_err_on_stop;
        $rose(estop_o[1]) |-> interlock_err_o[1];
    endproperty
    a_err_on_stop: assert property (p_err_on_stop)
        else $error("Stop raised without interlock error");

    property p_inh_off;
        !s.inh[1].enable |=> !estop_o[1] && !move_reject_o[1];
    endproperty
    a_inh_off: assert property (p_inh_off)
        else $error("Disabled inhibit still acted");

    property p_ntf_still;
        (s.ntf[1].enable && port_out[s.ntf[1].bit_sel]
         && !axis_moving_i[1])
        |=> digital_io_line_o[$past(s.ntf[1].bit_sel)]
            == $past(s.ntf[1].level);
    endproperty
    a_ntf_still: assert property (p_ntf_still)
        else $error("Standstill level not driven");

    property p_ntf_move;
        (s.ntf[1].enable && port_out[s.ntf[1].bit_sel]
         && axis_moving_i[1])
        |=> digital_io_line_o[$past(s.ntf[1].bit_sel)]
            != $past(s.ntf[1].level);
    endproperty
    a_ntf_move: assert property (p_ntf_move)
        else $error("Moving level not opposite of standstill");

    c_start: cover property (program_start_o[0]);
    c_estop: cover property ($rose(estop_o[1]));
    c_reject: cover property (move_reject_o[1]);
    c_irq: cover property ($rose(irq_o));

endmodule

// ==== testbench/dms_ext_circuit.sv ====
// Pulled-up external circuits sitting on the sixteen DIO lines
module dms_ext_circuit (
    // Device side
    input wire logic [15:0] dut_val_i,
    input wire logic [15:0] dut_oe_i,
    // External sources commanded by the bench
    input wire logic [15:0] ext_en_i,
    input wire logic [15:0] ext_val_i,
    // Resolved line level
    output logic [15:0] line_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // Device wins where enabled; an idle line floats up, never to X
    always_comb begin
        for (int b = 0; b < 16; b++) begin
            if (dut_oe_i[b]) begin
                line_o[b] = dut_val_i[b];
            end else if (ext_en_i[b]) begin
                line_o[b] = ext_val_i[b];
            end else begin
                line_o[b] = 1'b1;
            end
        end
    end
endmodule

// ==== testbench/tb_dms_dio_motion_event_sync.sv ====
// Self-checking bench of the DIO motion event block
module tb_dms_dio_motion_event_sync;
    timeunit 1ns;
    timeprecision 1ps;
    // ***********************************************************
    // Stimulus, observation and models
    // ***********************************************************
    logic clk_i = 0, rst_i = 1, awv = 0, wv = 0, bre = 0, arv = 0, rre = 0;
    logic awr, wr_o, bv, arr, rv, irq;
    logic [1:0] br, rr, ecfg, gr;
    logic [7:0] aw = 0, ar = 0;
    logic [31:0] wd = 0, rdat, gd, x = 32'h0000_000E, e, s, c;
    logic [15:0] dout, doe, line, ps, een = 0, evl = 0;
    logic [3:0] mov = 0, mc = 0, es, rej, ilk;
    int mismatches = 0, checks = 0, pc, ic, rc;
    always #5 clk_i = ~clk_i;
    dms_ext_circuit u_ext (.dut_val_i(dout), .dut_oe_i(doe),
        .ext_en_i(een), .ext_val_i(evl), .line_o(line));
    dms_dio_motion_event_sync u_dut (.clk_i(clk_i), .rst_i(rst_i),
        .s_axi_awvalid_i(awv), .s_axi_awaddr_i(aw), .s_axi_awready_o(awr),
        .s_axi_wvalid_i(wv), .s_axi_wdata_i(wd), .s_axi_wstrb_i(4'hF),
        .s_axi_wready_o(wr_o), .s_axi_bvalid_o(bv), .s_axi_bresp_o(br),
        .s_axi_bready_i(bre), .s_axi_arvalid_i(arv), .s_axi_araddr_i(ar),
        .s_axi_arready_o(arr), .s_axi_rvalid_o(rv), .s_axi_rdata_o(rdat),
        .s_axi_rresp_o(rr), .s_axi_rready_i(rre),
        .digital_io_line_i(line), .digital_io_line_o(dout),
        .digital_io_line_oe_o(doe), .axis_moving_i(mov), .move_cmd_i(mc),
        .program_start_o(ps), .estop_o(es), .emergency_stop_config_o(ecfg),
        .move_reject_o(rej), .interlock_err_o(ilk), .irq_o(irq));
    // ***********************************************************
    // Helpers: random source, bus cycles, compare, verdict
    // ***********************************************************
    function automatic logic [31:0] rnd();
        x ^= x << 13;
        x ^= x >> 17;
        x ^= x << 5;
        return x;
    endfunction
    task summarize();
        if (mismatches == 0 && checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task cmp(input logic [31:0] g, input logic [31:0] ex);
        checks++;
        if (g !== ex) begin
            mismatches++;
            $display("[ERR] %0t got %h expected %h", $time, g, ex);
        end
    endtask
    // Bounded wait for a handshake seen high at a rising edge
    task waitfor(input int sel);
        for (int n = 0; n < 40; n++) begin
            @(posedge clk_i);
            if ((sel == 0 ? awr : sel == 1 ? bv : sel == 2 ? arr : rv)
                === 1'b1) return;
        end
        mismatches++;
        summarize();
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        awv <= 1; wv <= 1; aw <= a; wd <= d; bre <= 1;
        waitfor(0);
        cmp(32'(wr_o), 32'h0000_0001);
        awv <= 0; wv <= 0;
        waitfor(1);
        bre <= 0;
    endtask
    task rd(input logic [7:0] a);
        @(posedge clk_i);
        arv <= 1; ar <= a; rre <= 1;
        waitfor(2);
        arv <= 0;
        waitfor(3);
        gd = rdat; gr = rr; rre <= 0;
    endtask
    // Count one-cycle pulses over a window
    task watch(input int n);
        pc = 0; ic = 0; rc = 0;
        repeat (n) begin
            @(posedge clk_i);
            pc += (ps[0] === 1'b1); ic += (ilk[1] === 1'b1);
            rc += (rej[1] === 1'b1);
        end
    endtask
    // ***********************************************************
    // Main sequence
    // ***********************************************************
    initial begin
        repeat (12) @(posedge clk_i);
        rst_i <= 0;
        @(posedge clk_i);
        cmp(32'(doe), 32'h0000_0000);
        rd(8'h10); cmp(gd, 32'h0000_FFFF);
        wr(8'h00, 32'h0000_0002); repeat (2) @(posedge clk_i);
        cmp(32'(doe), 32'h0000_FF00);
        // Random output words, then bitwise set and clear on top
        repeat (3) begin
            e = rnd(); s = rnd(); c = rnd();
            wr(8'h04, e); wr(8'h08, s); wr(8'h0C, c);
            e = (e | s) & ~c; repeat (2) @(posedge clk_i);
            cmp(32'(dout[15:8]), 32'(e[15:8]));
            rd(8'h10); cmp(gd, {16'h0000, e[15:8], 8'hFF});
        end
        // Stop behaviour code is passed straight to the motion core
        e = rnd(); wr(8'h18, e);
        cmp(32'(ecfg), 32'(e[1:0]));
        cmp(32'(br), 32'h0000_0000);
        // Falling edge on a trigger line of the input port
        wr(8'h14, 32'h0000_0001); wr(8'h20, 32'h0000_0001);
        een[0] <= 1; evl[0] <= 0; watch(8);
        cmp(32'(pc), 32'h0000_0001);
        cmp(32'(irq), 32'h0000_0001);
        rd(8'h1C); cmp(32'(gd[0]), 32'h0000_0001);
        // Inhibit of axis 1 from line 1, held high by the pull-up
        wr(8'h44, 32'h0000_0031); mov <= 4'h2; watch(6);
        cmp(32'(es[1]), 32'h0000_0001);
        cmp(32'(ic), 32'h0000_0001);
        cmp(32'(irq), 32'h0000_0000);
        rd(8'h1C); cmp(32'(gd[17]), 32'h0000_0001);
        // Stationary commands: asserted, wrong level, disabled
        for (int i = 0; i < 3; i++) begin
            wr(8'h44, i == 0 ? 32'h0000_0031 : i == 1 ? 32'h0000_0021
                : 32'h0000_0011);
            mov <= 0; @(posedge clk_i); mc <= 4'h2;
            @(posedge clk_i); mc <= 0; watch(4);
            cmp(32'(rc), 32'(i == 0));
            cmp(32'(ic), 32'(i == 0));
        end
        // Notify on line 9 at standstill and moving, then level zero while moving
        wr(8'h64, 32'h0000_0039); repeat (3) @(posedge clk_i);
        cmp(32'(dout[9]), 32'h0000_0001);
        mov <= 4'h2; repeat (3) @(posedge clk_i);
        cmp(32'(dout[9]), 32'h0000_0000);
        wr(8'h64, 32'h0000_0029); repeat (3) @(posedge clk_i);
        cmp(32'(dout[9]), 32'h0000_0001);
        // Inhibit from an output-port line must not act
        wr(8'h44, 32'h0000_0031); repeat (2) @(posedge clk_i);
        cmp(32'(es[1]), 32'h0000_0001);
        wr(8'h44, 32'h0000_0039); repeat (2) @(posedge clk_i);
        cmp(32'(es[1]), 32'h0000_0000);
        wr(8'h30, rnd()); cmp(32'(br), 32'h0000_0002);
        rd(8'h30); cmp(32'(gr), 32'h0000_0002);
        summarize();
    end
endmodule
